// [hw/eicsv_irq_ctrl.sv]
`timescale 1ns/1ps
// Contract
// - External pin edges interrupt only when enabled.
// - Edge select: one rising, zero falling.
// - Valid selected edge sets external flag.
// - Flag, global and pin enable vector.
// - Wake only from enables set before halt; periphEn2 bits are read live after halt, only whether any was set is captured.
// - Wake vectors if global enable, else continues.
// - One instruction after halt runs first.
// - Interrupt entry pushes return address.
// - Entry shadows context, status minus two bits.
// - Return restores every shadow copy.
// - Shadows readable and writable in bank 31; here they sit at 0xF64-0xF6B, in bank 30.
// - Peripheral interrupts need peripheral enable.
// - Rising enables arm pins, bits 7-6 zero.
// - Falling enables arm pins, bits 7-6 zero.
// - Armed edge sets pin flag and summary.
// - Pin flag set by armed matching edge.
// - Flags stay set until written zero.
module eicsv_irq_ctrl #(
   parameter int         PINS       = 6,
   parameter logic [7:0] WAKE_CAPABLE = 8'hE0
) (
   // Clock and reset.
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   // Register port.
   input  wire eicsv_pkg::eicsv_bus_t regReq,
   output logic [7:0]                 readData,
   // Pins and peripheral flags.
   input  wire logic                  extPin,
   input  wire logic [PINS-1:0]       portaPin,
   input  wire logic [7:0]            periphFlags,
   // Core handshake.
   input  wire logic                  irqAccept,
   input  wire logic                  irqReturn,
   input  wire logic                  haltEnter,
   input  wire logic                  instrDone,
   input  wire logic [14:0]           pcIn,
   input  wire eicsv_pkg::eicsv_ctx_t liveCtx,
   // Requests and context toward the core.
   output logic                       vectorRequest,
   output logic                       wakeUp,
   output logic                       stepHold,
   output logic                       pushReturn,
   output logic [14:0]                returnAddr,
   output logic                       restoreValid,
   output eicsv_pkg::eicsv_ctx_t      restoreCtx
);

   logic [7:0]              ctrl;         // Interrupt control bits that software owns.
   logic                    extFlag;      // External pin flag.
   logic [7:0]              option;       // Option register, edge select inside.
   logic [7:0]              periphEn2;    // Second peripheral enable register.
   logic [7:0]              riseEn;       // Rising change enables.
   logic [7:0]              fallEn;       // Falling change enables.
   logic [7:0]              chgFlags;     // Per-pin change flags.
   eicsv_pkg::eicsv_ctx_t   shadow;       // Shadow context copies.
   eicsv_pkg::eicsv_state_t state;        // Halt sequencing state.
   logic [3:0]              haltEnables;  // Enables captured at halt entry.
   logic [PINS:0]           riseSeen;     // Settled rising edges, bit PINS is the external pin.
   logic [PINS:0]           fallSeen;     // Settled falling edges.
   logic                    extEdge;      // Edge of the selected polarity.
   logic [7:0]              chgSet;       // Armed edges this cycle.
   logic                    summary;      // OR of the pin flags.
   logic                    extPend;      // External request, enable applied.
   logic                    chgPend;      // Change request, enable applied.
   logic                    perPend;      // Peripheral request, enables applied.
   logic                    wakeCond;     // Some source may end the halt.
   logic                    entryClear;   // Hardware clears global enable on entry.
   logic                    returnSet;    // Hardware sets global enable on return.

   if (PINS < 1 || PINS > 6) begin : gBadPins
      $error("eicsv_irq_ctrl supports one to six port pins");
   end

   // Tests whether an address falls in the shadow window.
   function automatic logic isShadow(input logic [11:0] a);
      isShadow = (a >= eicsv_pkg::ADDR_SHADOW_BASE) && (a <= eicsv_pkg::ADDR_SHADOW_LAST);
   endfunction

   // Byte position in the packed shadow for an address in the window.
   function automatic logic [2:0] shadowIdx(input logic [11:0] a);
      logic [11:0] off;
      off = a - eicsv_pkg::ADDR_SHADOW_BASE;
      shadowIdx = 3'h7 - off[2:0];
   endfunction

   // Write strobe qualified for one register.
   function automatic logic wrHit(input eicsv_pkg::eicsv_bus_t r, input logic [11:0] a);
      wrHit = r.wr && (r.addr == a);
   endfunction

   // Pin synchronisers for the port pins and the external pin.
   eicsv_pin_edge #(
      .WIDTH   (PINS + 1)
   ) uPins (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pinIn    ({extPin, portaPin}),
      .riseSeen (riseSeen),
      .fallSeen (fallSeen)
   );

   assign extEdge = option[eicsv_pkg::OPT_EDGE_SEL] ? riseSeen[PINS] : fallSeen[PINS];

   always_comb begin
      chgSet = 8'h00;
      chgSet[PINS-1:0] = (riseSeen[PINS-1:0] & riseEn[PINS-1:0]) | (fallSeen[PINS-1:0] & fallEn[PINS-1:0]);
   end

   assign summary = |chgFlags;

   assign extPend = extFlag && ctrl[eicsv_pkg::CTRL_EXT_EN];
   assign chgPend = summary && ctrl[eicsv_pkg::CTRL_CHANGE_EN];
   assign perPend = ctrl[eicsv_pkg::CTRL_PERIPH_EN] && |(periphFlags & periphEn2);

   assign wakeCond = (extFlag && haltEnables[0]) || (summary && haltEnables[1])
                  || (haltEnables[2] && |(periphFlags & periphEn2 & WAKE_CAPABLE & {8{haltEnables[3]}}));

   assign entryClear = irqAccept;
   assign returnSet  = irqReturn;

   // Interrupt control bits; entry clears and return sets the global enable.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= eicsv_pkg::CTRL_RESET;
      end else begin
         if (wrHit(regReq, eicsv_pkg::ADDR_IRQ_CONTROL)) begin
            ctrl <= regReq.wdata & eicsv_pkg::CTRL_WMASK;
         end
         if (entryClear) begin
            ctrl[eicsv_pkg::CTRL_GLOBAL_EN] <= 1'b0;
         end else if (returnSet) begin
            ctrl[eicsv_pkg::CTRL_GLOBAL_EN] <= 1'b1;
         end
      end
   end

   // external flag set wins over clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         extFlag <= 1'b0;
      end else if (extEdge) begin
         extFlag <= 1'b1;
      end else if (wrHit(regReq, eicsv_pkg::ADDR_IRQ_CONTROL)) begin
         extFlag <= regReq.wdata[eicsv_pkg::CTRL_EXT_FLAG];
      end
   end

   // Plain configuration registers.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         option    <= eicsv_pkg::OPTION_RESET;
         periphEn2 <= eicsv_pkg::REG_RESET;
         riseEn    <= eicsv_pkg::REG_RESET;
         fallEn    <= eicsv_pkg::REG_RESET;
      end else begin
         if (wrHit(regReq, eicsv_pkg::ADDR_OPTION)) begin
            option <= regReq.wdata;
         end
         if (wrHit(regReq, eicsv_pkg::ADDR_PERIPH_EN2)) begin
            periphEn2 <= regReq.wdata & eicsv_pkg::PERIPH_EN2_MASK;
         end
         if (wrHit(regReq, eicsv_pkg::ADDR_RISE_EN)) begin
            riseEn <= regReq.wdata & eicsv_pkg::PORT_MASK;
         end
         if (wrHit(regReq, eicsv_pkg::ADDR_FALL_EN)) begin
            fallEn <= regReq.wdata & eicsv_pkg::PORT_MASK;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         chgFlags <= eicsv_pkg::REG_RESET;
      end else if (wrHit(regReq, eicsv_pkg::ADDR_CHG_FLAGS)) begin
         chgFlags <= (regReq.wdata & eicsv_pkg::PORT_MASK & chgFlags) | chgSet;
      end else begin
         chgFlags <= chgFlags | chgSet;
      end
   end

   // Shadow copies: entry captures, software may rewrite them.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         shadow <= '0;
      end else if (irqAccept) begin
         shadow        <= liveCtx & eicsv_pkg::CTX_WMASK;
         shadow.status <= liveCtx.status & eicsv_pkg::STATUS_SAVE;
      end else if (regReq.wr && isShadow(regReq.addr)) begin
         shadow[shadowIdx(regReq.addr)*8 +: 8] <= regReq.wdata
                                                & eicsv_pkg::CTX_WMASK[shadowIdx(regReq.addr)*8 +: 8];
      end
   end

   // Read data, valid only in the cycle after the read strobe.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         readData <= 8'h00;
      end else if (regReq.rd) begin
         if (isShadow(regReq.addr)) begin
            readData <= shadow[shadowIdx(regReq.addr)*8 +: 8];
         end else begin
            case (regReq.addr)
               eicsv_pkg::ADDR_IRQ_CONTROL: readData <= ctrl | {6'h00, extFlag, summary};
               eicsv_pkg::ADDR_OPTION:      readData <= option;
               eicsv_pkg::ADDR_PERIPH_EN2:  readData <= periphEn2;
               eicsv_pkg::ADDR_RISE_EN:     readData <= riseEn;
               eicsv_pkg::ADDR_FALL_EN:     readData <= fallEn;
               eicsv_pkg::ADDR_CHG_FLAGS:   readData <= chgFlags;
               // Unmapped addresses read zero.
               default:                     readData <= 8'h00;
            endcase
         end
      end else begin
         readData <= 8'h00;
      end
   end

   // Halt sequencing: halt, wake, one instruction, then run.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state       <= eicsv_pkg::ST_RUN;
         haltEnables <= 4'h0;
         wakeUp      <= 1'b0;
         stepHold    <= 1'b0;
      end else begin
         wakeUp <= 1'b0;
         case (state)
            eicsv_pkg::ST_RUN: begin
               if (haltEnter) begin
                  state       <= eicsv_pkg::ST_HALT;
                  haltEnables <= {ctrl[eicsv_pkg::CTRL_PERIPH_EN], |periphEn2,
                                  ctrl[eicsv_pkg::CTRL_CHANGE_EN], ctrl[eicsv_pkg::CTRL_EXT_EN]};
               end
            end
            eicsv_pkg::ST_HALT: begin
               if (wakeCond) begin
                  state    <= eicsv_pkg::ST_STEP;
                  wakeUp   <= 1'b1;
                  stepHold <= 1'b1;
               end
            end
            eicsv_pkg::ST_STEP: begin
               if (instrDone) begin
                  state    <= eicsv_pkg::ST_RUN;
                  stepHold <= 1'b0;
               end
            end
            default: begin
               state    <= eicsv_pkg::ST_RUN;
               stepHold <= 1'b0;
            end
         endcase
      end
   end

   // after waking, vector only with global enable
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         vectorRequest <= 1'b0;
      end else begin
         vectorRequest <= (state == eicsv_pkg::ST_RUN) && !irqAccept && ctrl[eicsv_pkg::CTRL_GLOBAL_EN]
                          && (extPend || chgPend || perPend);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pushReturn <= 1'b0;
         returnAddr <= 15'h0000;
      end else begin
         pushReturn <= irqAccept;
         if (irqAccept) begin
            returnAddr <= pcIn;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         restoreValid <= 1'b0;
         restoreCtx   <= '0;
      end else begin
         restoreValid <= irqReturn;
         if (irqReturn) begin
            restoreCtx <= shadow;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   ext_edge_flag_a: assert property (extEdge |=> extFlag)
      else $error("external edge did not set the flag");
   vector_needs_global_a: assert property (vectorRequest |-> $past(ctrl[eicsv_pkg::CTRL_GLOBAL_EN]))
      else $error("vector raised without global enable");
   periph_gated_a: assert property (vectorRequest && !$past(ctrl[eicsv_pkg::CTRL_PERIPH_EN])
                                    |-> $past(extPend || chgPend))
      else $error("peripheral request passed without peripheral enable");
   push_return_a: assert property (irqAccept |=> pushReturn && returnAddr == $past(pcIn))
      else $error("return address not pushed on entry");
   shadow_capture_a: assert property (irqAccept |=> shadow.acc == $past(liveCtx.acc)
                      && shadow.status == ($past(liveCtx.status) & eicsv_pkg::STATUS_SAVE))
      else $error("context not shadowed on entry");
   restore_ctx_a: assert property (irqReturn |=> restoreValid && restoreCtx == $past(shadow))
      else $error("shadow not restored on return");
   pin_flag_set_a: assert property (|chgSet |=> (chgFlags & $past(chgSet)) == $past(chgSet))
      else $error("armed edge did not set its flag");
   summary_read_a: assert property (regReq.rd && regReq.addr == eicsv_pkg::ADDR_IRQ_CONTROL
                                    |=> readData[0] == $past(|chgFlags))
      else $error("summary flag read back wrong");
   rise_reserved_a: assert property (regReq.rd && regReq.addr == eicsv_pkg::ADDR_RISE_EN
                                     |=> readData[7:6] == 2'b00)
      else $error("reserved rising enable bits not zero");
   wake_step_a: assert property (state == eicsv_pkg::ST_HALT && wakeCond |=> wakeUp && stepHold ##1 !wakeUp)
      else $error("wake did not start the single step");
   step_blocks_vector_a: assert property (stepHold ##1 stepHold |-> !vectorRequest)
      else $error("vector raised during the post-halt instruction");

endmodule

// [hw/eicsv_pin_edge.sv]
`timescale 1ns/1ps
// Brings outside pins into the clock domain and reports settled edges.
module eicsv_pin_edge #(
   parameter int WIDTH = 7
) (
   // Clock and reset.
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // Raw pins and edge pulses.
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] riseSeen,
   output logic      [WIDTH-1:0] fallSeen
);

   logic [WIDTH-1:0] syncA;   // First stage, read only by the second.
   logic [WIDTH-1:0] syncB;   // Second stage.
   logic [WIDTH-1:0] syncC;   // Third stage.
   logic [WIDTH-1:0] settled; // Last level on which stages two and three agreed.

   // Refuses a pin count that leaves nothing to synchronise.
   if (WIDTH < 1) begin : gBadWidth
      $error("eicsv_pin_edge needs at least one pin");
   end

   // Three flip-flop synchroniser per pin.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA <= '0;
         syncB <= '0;
         syncC <= '0;
      end else begin
         syncA <= pinIn;
         syncB <= syncA;
         syncC <= syncB;
      end
   end

   // A change counts only once stages two and three agree.
   generate
      for (genvar i = 0; i < WIDTH; i++) begin : gPin
         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               settled[i]  <= 1'b0;
               riseSeen[i] <= 1'b0;
               fallSeen[i] <= 1'b0;
            end else begin
               riseSeen[i] <= (syncB[i] == syncC[i]) && syncC[i] && !settled[i];
               fallSeen[i] <= (syncB[i] == syncC[i]) && !syncC[i] && settled[i];
               if (syncB[i] == syncC[i]) begin
                  settled[i] <= syncC[i];
               end
            end
         end
      end
   endgenerate

endmodule

// [hw/eicsv_pkg.sv]
package eicsv_pkg;

   // Register bus widths.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // Register addresses.
   localparam logic [11:0] ADDR_IRQ_CONTROL = 12'h00B;
   localparam logic [11:0] ADDR_OPTION      = 12'h095;
   localparam logic [11:0] ADDR_PERIPH_EN2  = 12'h092;
   localparam logic [11:0] ADDR_RISE_EN     = 12'h391;
   localparam logic [11:0] ADDR_FALL_EN     = 12'h392;
   localparam logic [11:0] ADDR_CHG_FLAGS   = 12'h393;
   // Shadow copies sit in data bank 30, eight consecutive bytes from this base.
   localparam logic [11:0] ADDR_SHADOW_BASE = 12'hF64;
   localparam logic [11:0] ADDR_SHADOW_LAST = 12'hF6B;

   // Field positions inside the interrupt control register.
   localparam int CTRL_GLOBAL_EN = 7;
   localparam int CTRL_PERIPH_EN = 6;
   localparam int CTRL_EXT_EN    = 4;
   localparam int CTRL_CHANGE_EN = 3;
   localparam int CTRL_EXT_FLAG  = 1;
   localparam int CTRL_SUMMARY   = 0;
   // Field position of the edge select inside the option register.
   localparam int OPT_EDGE_SEL = 6;

   // Implemented bits of each register; others read as zero.
   localparam logic [7:0] PERIPH_EN2_MASK = 8'hEC;
   localparam logic [7:0] PORT_MASK       = 8'h3F;
   localparam logic [7:0] CTRL_WMASK      = 8'hDA;
   localparam logic [7:0] STATUS_SAVE     = 8'hE7;

   // Values after reset.
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [7:0] REG_RESET    = 8'h00;

   // Core context that is shadowed on interrupt entry.
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] status;
      logic [7:0] bankSel;
      logic [7:0] ptr0Low;
      logic [7:0] ptr0High;
      logic [7:0] ptr1Low;
      logic [7:0] ptr1High;
      logic [7:0] pcHigh;
   } eicsv_ctx_t;

   // Writable bits of each shadow byte, in struct order.
   localparam logic [63:0] CTX_WMASK = 64'hFFE71FFFFFFFFF7F;

   // One register bus request.
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } eicsv_bus_t;

   // Halt sequencing states.
   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_HALT = 2'b01,
      ST_STEP = 2'b10
   } eicsv_state_t;

endpackage

// [test/edge_irq_and_context_save_bench.sv]
`timescale 1ns/1ps
// Self-checking bench; it plays both software and the core.
module edge_irq_and_context_save_bench;
   // Stimulus, driven by the bench.
   logic                  core_clk    = 1'b0;
   logic                  reset_n     = 1'b0;
   eicsv_pkg::eicsv_bus_t regReq      = '0;
   logic [7:0]            periphFlags = 8'h00;
   logic [3:0]            coreCmd     = 4'h0;
   logic [14:0]           pcIn        = 15'h0000;
   eicsv_pkg::eicsv_ctx_t liveCtx     = '0;
   logic                  extLevel    = 1'b0;
   logic [5:0]            portLevel   = 6'h00;
   // Pins and design outputs.
   logic                  extPin;
   logic [5:0]            portaPin;
   logic [7:0]            readData;
   logic                  vectorRequest;
   logic                  wakeUp;
   logic                  stepHold;
   logic                  pushReturn;
   logic                  restoreValid;
   logic [14:0]           returnAddr;
   eicsv_pkg::eicsv_ctx_t restoreCtx;
   // Bookkeeping.
   int                    n_fail      = 0;
   int                    num_checks  = 0;
   int                    cycles      = 0;
   int                    i;
   logic [7:0]            rdVal;
   logic                  seen;
   logic [63:0]           ctxVal      = 64'h1122334455667788;

   // The 20 MHz clock.
   always #25 core_clk = ~core_clk;

   eicsv_pin_source eicsv_pin_source_i (.extLevel(extLevel), .portLevel(portLevel), .extPin(extPin),
      .portaPin(portaPin));

   eicsv_irq_ctrl eicsv_irq_ctrl_i (.core_clk(core_clk), .reset_n(reset_n), .regReq(regReq),
      .readData(readData), .extPin(extPin), .portaPin(portaPin), .periphFlags(periphFlags),
      .irqAccept(coreCmd[3]), .irqReturn(coreCmd[2]), .haltEnter(coreCmd[1]), .instrDone(coreCmd[0]),
      .pcIn(pcIn), .liveCtx(liveCtx), .vectorRequest(vectorRequest), .wakeUp(wakeUp),
      .stepHold(stepHold), .pushReturn(pushReturn), .returnAddr(returnAddr),
      .restoreValid(restoreValid), .restoreCtx(restoreCtx));

   // One-cycle register write.
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regReq.addr <= a;
      regReq.wdata <= d;
      regReq.wr <= 1'b1;
      @(posedge core_clk);
      regReq.wr <= 1'b0;
   endtask

   // Read, then compare the data of the following cycle.
   task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      regReq.addr <= a;
      regReq.rd <= 1'b1;
      @(posedge core_clk);
      regReq.rd <= 1'b0;
      #1 rdVal = readData;
      chkv(what, {56'h0, exp}, {56'h0, rdVal});
   endtask

   // Compares a value.
   task automatic chkv(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Compares a single flag.
   task automatic chkb(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask

   // One-cycle pulse on a core strobe; returns just after the sampling edge.
   task automatic pulse(input int b);
      @(posedge core_clk);
      coreCmd[b] <= 1'b1;
      @(posedge core_clk);
      coreCmd[b] <= 1'b0;
      #1;
   endtask

   // Moves the pins, then waits out synchroniser and flag register.
   task automatic pins(input logic e, input logic [5:0] p);
      @(posedge core_clk);
      extLevel <= e;
      portLevel <= p;
      repeat (6) @(posedge core_clk);
   endtask

   // Looks for a wake pulse during ten cycles.
   task automatic waitWake;
      seen = 1'b0;
      repeat (10) begin
         @(posedge core_clk);
         #1;
         if (wakeUp === 1'b1) begin
            seen = 1'b1;
         end
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic finish_test;
      $display("Checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Cuts a hang short.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         finish_test();
      end
   end

   // Main sequence.
   initial begin
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      rchk("control", eicsv_pkg::ADDR_IRQ_CONTROL, 8'h00);
      rchk("option", eicsv_pkg::ADDR_OPTION, 8'hFF);
      rchk("periph_en2", eicsv_pkg::ADDR_PERIPH_EN2, 8'h00);
      rchk("flags", eicsv_pkg::ADDR_CHG_FLAGS, 8'h00);
      rchk("unmapped", 12'h3FF, 8'h00);
      wr(eicsv_pkg::ADDR_PERIPH_EN2, 8'hFF);
      rchk("periph_en2", eicsv_pkg::ADDR_PERIPH_EN2, 8'hEC);
      wr(eicsv_pkg::ADDR_RISE_EN, 8'hFF);
      rchk("rise", eicsv_pkg::ADDR_RISE_EN, 8'h3F);
      wr(eicsv_pkg::ADDR_FALL_EN, 8'hFF);
      rchk("fall", eicsv_pkg::ADDR_FALL_EN, 8'h3F);
      $display("test registers done");
      wr(eicsv_pkg::ADDR_PERIPH_EN2, 8'h00);
      wr(eicsv_pkg::ADDR_RISE_EN, 8'h05);
      wr(eicsv_pkg::ADDR_FALL_EN, 8'h02);
      pins(1'b0, 6'h3F);
      rchk("flags", eicsv_pkg::ADDR_CHG_FLAGS, 8'h05);
      rchk("summary", eicsv_pkg::ADDR_IRQ_CONTROL, 8'h01);
      pins(1'b0, 6'h00);
      rchk("flags", eicsv_pkg::ADDR_CHG_FLAGS, 8'h07);
      wr(eicsv_pkg::ADDR_CHG_FLAGS, 8'h05);
      rchk("flags", eicsv_pkg::ADDR_CHG_FLAGS, 8'h05);
      wr(eicsv_pkg::ADDR_CHG_FLAGS, 8'h00);
      rchk("summary", eicsv_pkg::ADDR_IRQ_CONTROL, 8'h00);
      $display("test port change done");
      wr(eicsv_pkg::ADDR_IRQ_CONTROL, 8'h90);
      pins(1'b1, 6'h00);
      #1 chkb("vector", 1'b1, vectorRequest);
      rchk("control", eicsv_pkg::ADDR_IRQ_CONTROL, 8'h92);
      wr(eicsv_pkg::ADDR_IRQ_CONTROL, 8'h10);
      wr(eicsv_pkg::ADDR_OPTION, 8'hBF);
      pins(1'b0, 6'h00);
      rchk("falling", eicsv_pkg::ADDR_IRQ_CONTROL, 8'h12);
      wr(eicsv_pkg::ADDR_IRQ_CONTROL, 8'h10);
      pins(1'b1, 6'h00);
      rchk("rising", eicsv_pkg::ADDR_IRQ_CONTROL, 8'h10);
      wr(eicsv_pkg::ADDR_IRQ_CONTROL, 8'h80);
      pins(1'b0, 6'h00);
      #1 chkb("vector", 1'b0, vectorRequest);
      wr(eicsv_pkg::ADDR_IRQ_CONTROL, 8'h00);
      $display("test pin edge done");
      wr(eicsv_pkg::ADDR_PERIPH_EN2, 8'h04);
      @(posedge core_clk) periphFlags <= 8'h04;
      wr(eicsv_pkg::ADDR_IRQ_CONTROL, 8'h80);
      repeat (3) @(posedge core_clk);
      #1 chkb("vector", 1'b0, vectorRequest);
      wr(eicsv_pkg::ADDR_IRQ_CONTROL, 8'hC0);
      @(posedge core_clk);
      #1 chkb("vector", 1'b1, vectorRequest);
      @(posedge core_clk) periphFlags <= 8'h00;
      $display("test peripheral done");
      @(posedge core_clk) liveCtx <= ctxVal;
      pcIn <= 15'h1234;
      pulse(3);
      chkb("push", 1'b1, pushReturn);
      chkv("return", 64'h1234, {49'h0, returnAddr});
      for (i = 0; i < 8; i++) begin
         rchk("shadow", eicsv_pkg::ADDR_SHADOW_BASE + 12'(i),
              8'((ctxVal & eicsv_pkg::CTX_WMASK) >> (56 - 8 * i)));
      end
      @(posedge core_clk) liveCtx <= ~ctxVal;
      wr(eicsv_pkg::ADDR_SHADOW_BASE, 8'h5A);
      pulse(2);
      chkb("restore", 1'b1, restoreValid);
      chkv("context", {8'h5A, ctxVal[55:0]} & eicsv_pkg::CTX_WMASK, restoreCtx);
      $display("test context done");
      wr(eicsv_pkg::ADDR_IRQ_CONTROL, 8'hC0);
      wr(eicsv_pkg::ADDR_PERIPH_EN2, 8'h80);
      pulse(1);
      @(posedge core_clk) periphFlags <= 8'h80;
      waitWake();
      chkb("wake", 1'b1, seen);
      chkb("step", 1'b1, stepHold);
      chkb("vector", 1'b0, vectorRequest);
      pulse(0);
      @(posedge core_clk);
      #1 chkb("step", 1'b0, stepHold);
      chkb("vector", 1'b1, vectorRequest);
      wr(eicsv_pkg::ADDR_PERIPH_EN2, 8'h00);
      @(posedge core_clk) periphFlags <= 8'h00;
      pulse(1);
      wr(eicsv_pkg::ADDR_PERIPH_EN2, 8'h80);
      @(posedge core_clk) periphFlags <= 8'h80;
      waitWake();
      chkb("wake", 1'b0, seen);
      $display("test halt done");
      finish_test();
   end
endmodule

// [test/eicsv_pin_source.sv]
`timescale 1ns/1ps
// Model of the outside world that drives the interrupt and port pins.
module eicsv_pin_source (
   // Levels that the bench asks for.
   input  wire logic       extLevel,
   input  wire logic [5:0] portLevel,
   // Pin levels that the block sees.
   output logic            extPin,
   output logic [5:0]      portaPin
);
   // Pins start low so the synchronisers see a defined level in reset.
   initial begin
      extPin = 1'b0;
      portaPin = 6'h00;
   end
   // edges off clock phase
   // Pins move 13 ns after the request, so edges fall between clock edges.
   always @(extLevel) begin
      extPin <= #13 extLevel;
   end
   // levels held long
   // Each level is held for several cycles, so no short pulse is lost.
   always @(portLevel) begin
      portaPin <= #13 portLevel;
   end
endmodule
